// >>> src/delay_pulse_timer.v
`timescale 1ns/100ps
`include "timer_consts.vh"

// ==========================================
// triggered delay and pulse timer with line routing
module delay_pulse_timer #(
    parameter TIME_W = `TIME_W,
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter TICK_W = `TICK_W
) (
    input wire clk,
    input wire rst_b,
    input wire clk_en,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire exposure_window_signal,
    input wire readout_window_signal,
    input wire external_input_line,
    output reg timer_output,
    output reg line_out
);

    // ==========================================
    // states
    localparam [1:0] IDLE = 2'b00;
    localparam [1:0] DELAY = 2'b01;
    localparam [1:0] PULSE = 2'b10;
    localparam [1:0] FOLLOW = 2'b11;

    localparam [TIME_W-1:0] TIME_MAX = `TIME_MAX_US;
    localparam [TIME_W-1:0] TIME_ONE = {{(TIME_W-1){1'b0}}, 1'b1};
    localparam [TIME_W-1:0] TIME_ZERO = {TIME_W{1'b0}};

    // ==========================================
    // functions

    // true when one more tick finishes the interval
    function reached;
        input [TIME_W-1:0] count;
        input [TIME_W-1:0] target;
        begin
            reached = ({1'b0, count} + {{TIME_W{1'b0}}, 1'b1}) >= {1'b0, target};
        end
    endfunction

    // out-of-range writes saturate instead of wrapping
    function [TIME_W-1:0] clamp_time;
        input [31:0] value;
        input [TIME_W-1:0] floor;
        begin
            if (value > {{(32 - TIME_W){1'b0}}, TIME_MAX}) begin
                clamp_time = TIME_MAX;
            end else if (value[TIME_W-1:0] < floor) begin
                clamp_time = floor;
            end else begin
                clamp_time = value[TIME_W-1:0];
            end
        end
    endfunction

    // ==========================================
    // configuration registers
    reg [`CTRL_W-1:0] ctrl;
    reg [TIME_W-1:0] start_delay;
    reg [TIME_W-1:0] pulse_length;
    reg timer_restart;

    wire [1:0] trigger_origin_select = ctrl[`CTRL_ORIGIN];
    wire [1:0] trigger_polarity_mode = ctrl[`CTRL_MODE];
    wire [2:0] line_output_select = ctrl[`CTRL_LINE_SEL];
    wire output_polarity_invert = ctrl[`CTRL_INVERT];
    wire user_output_value = ctrl[`CTRL_USER_VAL];

    wire wr_ctrl = wr && (addr == `REG_CTRL);
    wire wr_delay = wr && (addr == `REG_DELAY);
    wire wr_length = wr && (addr == `REG_LENGTH);
    wire wr_restart = wr && (addr == `REG_RESTART) && wdata[`RESTART_BIT];

    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= `CTRL_RST;
            start_delay <= `DELAY_RST;
            pulse_length <= `LENGTH_RST;
            timer_restart <= 1'b0;
        end else if (clk_en) begin
            timer_restart <= wr_restart;
            if (wr_ctrl) begin
                ctrl <= wdata[`CTRL_W-1:0];
            end
            if (wr_delay) begin
                start_delay <= clamp_time(wdata, TIME_ZERO);
            end
            if (wr_length) begin
                pulse_length <= clamp_time(wdata, TIME_ONE);
            end
        end
    end

    // ==========================================
    // source selection

    // the camera signals share this clock; only the pin needs syncing
    wire ext_line_sync;

    line_sync u_line_sync (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_in(external_input_line),
        .sync_out(ext_line_sync)
    );

    reg src_level;
    reg src_enabled;

    always @* begin
        src_level = 1'b0;
        src_enabled = 1'b1;
        case (trigger_origin_select)
            `ORIGIN_EXPOSURE: begin
                src_level = exposure_window_signal;
            end
            `ORIGIN_READOUT: begin
                src_level = readout_window_signal;
            end
            `ORIGIN_LINE: begin
                src_level = ext_line_sync;
            end
            default: begin
                src_enabled = 1'b0;
            end
        endcase
    end

    // ==========================================
    // trigger detection
    reg src_prev;

    always @(posedge clk) begin
        if (!rst_b) begin
            src_prev <= 1'b0;
        end else if (clk_en) begin
            src_prev <= src_level;
        end
    end

    wire rise = src_level && !src_prev;
    wire fall = !src_level && src_prev;
    wire level_mode = trigger_polarity_mode[1];

    // level modes count low as active when polarity says so
    wire src_active = (trigger_polarity_mode == `MODE_LOW) ? !src_level : src_level;

    reg trigger;

    always @* begin
        trigger = 1'b0;
        case (trigger_polarity_mode)
            `MODE_RISE: begin
                trigger = rise;
            end
            `MODE_FALL: begin
                trigger = fall;
            end
            `MODE_HIGH: begin
                trigger = src_level;
            end
            `MODE_LOW: begin
                trigger = !src_level;
            end
            default: begin
                trigger = 1'b0;
            end
        endcase
    end

    // ==========================================
    // time base
    reg [1:0] state;
    wire tick;
    wire start = (state == IDLE) && src_enabled && trigger;

    us_tick #(
        .CYCLES(TICK_CYCLES),
        .W(TICK_W)
    ) u_us_tick (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .restart(start || timer_restart),
        .tick(tick)
    );

    // ==========================================
    // timer sequencing
    reg [1:0] next_state;
    reg [TIME_W-1:0] count;
    reg [TIME_W-1:0] next_count;
    reg next_timer_output;

    // the phase after the delay depends on the mode
    wire [1:0] after_delay = level_mode ? FOLLOW : PULSE;

    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            IDLE: begin
                next_count = TIME_ZERO;
                if (start) begin
                    if (start_delay == TIME_ZERO) begin
                        next_state = after_delay;
                    end else begin
                        next_state = DELAY;
                    end
                end
            end
            DELAY: begin
                // edges here are dropped, not queued
                if (tick) begin
                    if (reached(count, start_delay)) begin
                        next_state = after_delay;
                        next_count = TIME_ZERO;
                    end else begin
                        next_count = count + TIME_ONE;
                    end
                end
            end
            PULSE: begin
                if (tick) begin
                    if (reached(count, pulse_length)) begin
                        next_state = IDLE;
                        next_count = TIME_ZERO;
                    end else begin
                        next_count = count + TIME_ONE;
                    end
                end
            end
            FOLLOW: begin
                if (!src_active) begin
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
                next_count = TIME_ZERO;
            end
        endcase
        if (!src_enabled || timer_restart) begin
            next_state = IDLE;
            next_count = TIME_ZERO;
        end
    end

    always @* begin
        case (next_state)
            PULSE: begin
                next_timer_output = 1'b1;
            end
            FOLLOW: begin
                next_timer_output = src_active;
            end
            default: begin
                next_timer_output = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            state <= IDLE;
            count <= TIME_ZERO;
            timer_output <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            count <= next_count;
            timer_output <= next_timer_output;
        end
    end

    // ==========================================
    // output line routing
    reg routed;
    reg next_line_out;

    always @* begin
        routed = 1'b0;
        case (line_output_select)
            `LINE_EXPOSURE: begin
                routed = exposure_window_signal;
            end
            `LINE_READOUT: begin
                routed = readout_window_signal;
            end
            `LINE_USER: begin
                routed = user_output_value;
            end
            `LINE_TIMER: begin
                routed = timer_output;
            end
            default: begin
                routed = 1'b0;
            end
        endcase
        // a disabled line stays low, inversion or not
        if (line_output_select == `LINE_OFF) begin
            next_line_out = 1'b0;
        end else begin
            next_line_out = routed ^ output_polarity_invert;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            line_out <= 1'b0;
        end else if (clk_en) begin
            line_out <= next_line_out;
        end
    end

    // ==========================================
    // register read port
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = `DATA_ZERO;
        if (rd) begin
            case (addr)
                `REG_CTRL: begin
                    next_rdata[`CTRL_W-1:0] = ctrl;
                end
                `REG_DELAY: begin
                    next_rdata[TIME_W-1:0] = start_delay;
                end
                `REG_LENGTH: begin
                    next_rdata[TIME_W-1:0] = pulse_length;
                end
                `REG_STATUS: begin
                    next_rdata[`STAT_OUT] = timer_output;
                    next_rdata[`STAT_STATE] = state;
                    next_rdata[`STAT_SRC] = src_level;
                    next_rdata[`STAT_LINE] = line_out;
                end
                `REG_COUNT: begin
                    next_rdata[TIME_W-1:0] = count;
                end
                default: begin
                    next_rdata = `DATA_ZERO;
                end
            endcase
        end
    end

    // data stands for one cycle only, zero otherwise
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= `DATA_ZERO;
        end else if (clk_en) begin
            rdata <= next_rdata;
        end
    end

endmodule

// >>> src/line_sync.v
`timescale 1ns/100ps
// ==========================================
// two-stage synchroniser for an outside pin
module line_sync (
    input wire clk,
    input wire rst_b,
    input wire clk_en,
    input wire async_in,
    output wire sync_out
);
    reg stage_a;
    reg stage_b;

    always @(posedge clk) begin
        if (!rst_b) begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
        end else if (clk_en) begin
            stage_a <= async_in;
            stage_b <= stage_a;
        end
    end

    assign sync_out = stage_b;
endmodule

// >>> src/timer_consts.vh
// Notes on behaviour
// - line output can carry the timer signal
// - origin off: timer never starts
// - sources: exposure, readout, external line
// - external line selected drives timer source
// - rising mode starts on low-to-high
// - falling mode starts on high-to-low
// - level-high: output high while source high
// - level-low: output high while source low
// - edge modes: pulse lasts programmed length
// - start delay before output may assert
// - restart clears delay and pulse, resumes
// - trigger, then delay, then follow level
// - exposure signal high during each exposure
// - inversion flips routed line signal
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ==========================================
// register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_LENGTH 8'h08
`define REG_RESTART 8'h0C
`define REG_STATUS 8'h10
`define REG_COUNT 8'h14

// ==========================================
// control register fields
`define CTRL_W 9
`define CTRL_ORIGIN 1:0
`define CTRL_MODE 3:2
`define CTRL_LINE_SEL 6:4
`define CTRL_INVERT 7
`define CTRL_USER_VAL 8
`define RESTART_BIT 0

// ==========================================
// status register fields
`define STAT_OUT 0
`define STAT_STATE 2:1
`define STAT_SRC 3
`define STAT_LINE 4

// ==========================================
// reset values
`define CTRL_RST 9'h000
`define DELAY_RST 26'h000_0000
`define LENGTH_RST 26'h000_0001
`define DATA_ZERO 32'h0000_0000

// ==========================================
// trigger origins
`define ORIGIN_OFF 2'h0
`define ORIGIN_EXPOSURE 2'h1
`define ORIGIN_READOUT 2'h2
`define ORIGIN_LINE 2'h3

// ==========================================
// trigger polarity modes
`define MODE_RISE 2'h0
`define MODE_FALL 2'h1
`define MODE_HIGH 2'h2
`define MODE_LOW 2'h3

// ==========================================
// output line sources
`define LINE_OFF 3'h0
`define LINE_EXPOSURE 3'h1
`define LINE_READOUT 3'h2
`define LINE_USER 3'h3
`define LINE_TIMER 3'h4

// ==========================================
// timing: 60,000,000 us ceiling for delay and length
`define TIME_MAX_US 26'h393_8700
`define TIME_W 26
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TICK_W 8

`endif

// >>> src/us_tick.v
`timescale 1ns/100ps
// ==========================================
// microsecond time base
module us_tick #(
    parameter CYCLES = 100,
    parameter W = 8
) (
    input wire clk,
    input wire rst_b,
    input wire clk_en,
    input wire restart,
    output wire tick
);
    localparam [31:0] LAST_FULL = CYCLES - 1;
    localparam [W-1:0] LAST = LAST_FULL[W-1:0];
    localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
    reg [W-1:0] cnt;

    // restart realigns the base so a delay is whole microseconds from the trigger
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt <= {W{1'b0}};
        end else if (clk_en) begin
            if (restart || cnt == LAST) begin
                cnt <= {W{1'b0}};
            end else begin
                cnt <= cnt + ONE;
            end
        end
    end

    assign tick = clk_en && !restart && (cnt == LAST);
endmodule

// >>> verif/delay_pulse_timer_sva.sv
`timescale 1ns/100ps
// ==========================================
// port checker
module timer_chk #(
    parameter TICK_CYCLES = 100
) (
    input wire clk,
    input wire rst_b,
    input wire clk_en,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire exposure_window_signal,
    input wire readout_window_signal,
    input wire external_input_line,
    input wire timer_output,
    input wire line_out
);
    reg [8:0] ctl;
    reg [31:0] dly, len, hi, cnt, since;
    reg act_d;
    wire w = wr && clk_en;
    wire src = ctl[1:0] == 2'h1 ? exposure_window_signal :
        ctl[1:0] == 2'h2 ? readout_window_signal : external_input_line;
    wire act = ctl[2] ? !src : src;
    wire lsrc = ctl[6:4] == 3'h1 ? exposure_window_signal : ctl[6:4] == 3'h2 ?
        readout_window_signal : ctl[6:4] == 3'h3 ? ctl[8] : timer_output;
    // edge is acted on one cycle after the source moves; the pin synchroniser adds two
    wire [31:0] lat = 1 + dly * TICK_CYCLES + (ctl[1:0] == 2'h3 ? 2 : 0);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always @(posedge clk) begin
        if (!rst_b) begin
            ctl <= 9'h000;
            dly <= 32'h0000_0000;
            len <= 32'h0000_0001;
            hi <= 32'h0000_0000;
            cnt <= 32'h0000_0000;
            since <= 32'h0000_0000;
            act_d <= 1'b0;
        end else begin
            if (w && addr == 8'h00) ctl <= wdata[8:0];
            if (w && addr == 8'h04) dly <= wdata;
            if (w && addr == 8'h08) len <= wdata == 32'h0000_0000 ? 32'h0000_0001 : wdata;
            hi <= timer_output ? hi + 1 : 32'h0000_0000;
            cnt <= (act && !act_d) ? 32'h0000_0001 : cnt + 1;
            since <= wr ? 32'h0000_0000 : since + 1;
            act_d <= act;
        end
    end
    reset_quiet_a: assert property ($rose(rst_b) |-> !timer_output && !line_out && rdata == 0)
        else $error("outputs not clear after reset");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    line_route_a: assert property ($past(ctl[6:4]) != 3'h0 |-> line_out == ($past(lsrc) ^ $past(ctl[7])))
        else $error("line level wrong");
    line_off_a: assert property ($past(ctl[6:4]) == 3'h0 |-> !line_out)
        else $error("line driven while off");
    origin_off_a: assert property ($past(ctl[1:0]) == 2'h0 |-> !timer_output)
        else $error("timer active with origin off");
    pulse_max_a: assert property (timer_output && !ctl[3] && since > hi + 4 |-> hi < len * TICK_CYCLES)
        else $error("pulse too long");
    pulse_len_a: assert property ($fell(timer_output) && !ctl[3] && since > hi + 4 |-> hi == len * TICK_CYCLES)
        else $error("pulse length wrong");
    start_delay_a: assert property ($rose(timer_output) && !ctl[3] && since > cnt |-> cnt == lat)
        else $error("start delay wrong");
    level_follow_a: assert property (timer_output && ctl[3] && since > 8 |-> $past(act) || $past(act, 2))
        else $error("level output without source");
endmodule

bind delay_pulse_timer timer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk(clk), .rst_b(rst_b),
    .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .exposure_window_signal(exposure_window_signal), .readout_window_signal(readout_window_signal),
    .external_input_line(external_input_line), .timer_output(timer_output), .line_out(line_out));

// >>> verif/line_watcher.sv
`timescale 1ns/100ps
// ==========================================
// far equipment: counts line pulses and their width
module line_watcher (
    input wire clk,
    input wire line_out,
    output reg [31:0] pulses,
    output reg [31:0] width
);
    reg [31:0] run;
    initial begin
        pulses = 0;
        width = 0;
        run = 0;
    end
    // width is taken when the line drops, so a stuck line never counts
    always @(posedge clk) begin
        run <= line_out ? run + 1 : 0;
        if (!line_out && run != 0) begin
            pulses <= pulses + 1;
            width <= run;
        end
    end
endmodule

// >>> verif/triggered_delay_pulse_timer_tb_top.sv
`timescale 1ns/100ps
// ==========================================
// bench
module triggered_delay_pulse_timer_tb_top;
    // short tick keeps the run small
    localparam T = 4;
    reg clk, rst_b, clk_en, wr, rd, exp_sig, rdo_sig, ext_pin;
    reg [7:0] addr;
    reg [31:0] wdata;
    wire [31:0] rdata, pulses, width;
    wire tout, lout;
    integer fail_count, checks_done;
    delay_pulse_timer #(.TICK_CYCLES(T)) DUT (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .exposure_window_signal(exp_sig),
        .readout_window_signal(rdo_sig), .external_input_line(ext_pin), .timer_output(tout), .line_out(lout));
    line_watcher far (.clk(clk), .line_out(lout), .pulses(pulses), .width(width));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task check(input string what, input [31:0] seen, input [31:0] want);
        begin
            checks_done = checks_done + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("BAD %s expected %0h seen %0h", what, want, seen);
            end
        end
    endtask
    task cyc(input integer k);
        begin
            repeat (k) @(posedge clk);
            #1;
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rreg(input [7:0] a, input [31:0] want);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            check("rdata", rdata, want);
        end
    endtask
    task src(input [1:0] o, input v);
        begin
            @(posedge clk);
            if (o == 2'h1) exp_sig <= v;
            if (o == 2'h2) rdo_sig <= v;
            if (o == 2'h3) ext_pin <= v;
        end
    endtask
    // bounded wait for the timer output to reach v
    task wt(input v, output integer k);
        begin
            k = 0;
            while (tout !== v && k < 5000) begin
                cyc(1);
                k = k + 1;
            end
        end
    endtask
    task t_reset;
        begin
            check("outs", {tout, lout}, 0);
            rreg(8'h00, 0);
            rreg(8'h04, 0);
            rreg(8'h08, 1);
            wreg(8'h40, 32'hFFFF_FFFF);
            rreg(8'h40, 0);
            wreg(8'h0C, 1);
            rreg(8'h0C, 0);
            $display("reset test done");
        end
    endtask
    task t_line;
        integer s, i;
        begin
            src(1, 1);
            src(2, 1);
            src(3, 1);
            cyc(10);
            check("off", tout, 0);
            for (s = 0; s < 5; s = s + 1) begin
                for (i = 0; i < 2; i = i + 1) begin
                    wreg(8'h00, {23'h0, 1'b1, i[0], s[2:0], 4'h0});
                    cyc(2);
                    check("line", lout, s == 0 ? 0 : (s != 4) ^ i);
                end
            end
            $display("line test done");
        end
    endtask
    task t_edge(input [1:0] o, input f);
        integer d, k, p0;
        begin
            d = o - 1;
            // origin off first, so presetting the source cannot fire the last mode
            wreg(8'h00, 32'h0000_0040);
            src(o, f);
            wreg(8'h04, d);
            wreg(8'h08, 32'h0000_0003);
            wreg(8'h00, {23'h0, 2'b0, 3'h4, 1'b0, f, o});
            cyc(4);
            p0 = pulses;
            src(o, !f);
            wt(1, k);
            check("delay", k, 1 + d * T + (o == 3 ? 2 : 0));
            // edges inside the pulse must not restart or queue
            src(o, f);
            src(o, !f);
            wt(0, k);
            check("width", k + 2, 3 * T);
            cyc(3);
            check("line width", width, 3 * T);
            cyc(d * T + 20);
            check("pulses", pulses, p0 + 1);
            $display("edge test done");
        end
    endtask
    task t_level(input lo);
        integer k;
        begin
            wreg(8'h00, 32'h0000_0040);
            src(1, lo);
            wreg(8'h04, 32'h0000_0002);
            wreg(8'h00, {23'h0, 2'b0, 3'h4, 1'b1, lo, 2'h1});
            cyc(4);
            src(1, !lo);
            wt(1, k);
            check("level delay", k, 1 + 2 * T);
            cyc(12);
            check("level hold", tout, 1);
            src(1, lo);
            wt(0, k);
            check("level drop", k, 1);
            $display("level test done");
        end
    endtask
    task t_restart;
        integer k, p0;
        begin
            wreg(8'h00, 32'h0000_0040);
            src(1, 0);
            wreg(8'h04, 32'h0000_0005);
            wreg(8'h00, 32'h0000_0041);
            cyc(2);
            p0 = pulses;
            src(1, 1);
            cyc(3);
            wreg(8'h0C, 32'h0000_0001);
            cyc(5 * T + 20);
            check("restart", pulses - p0 + tout, 0);
            src(1, 0);
            src(1, 1);
            wt(1, k);
            check("resume", k, 1 + 5 * T);
            wt(0, k);
            $display("restart test done");
        end
    endtask
    task t_reset2;
        begin
            wreg(8'h04, 0);
            src(1, 0);
            src(1, 1);
            cyc(3);
            check("pulse", tout, 1);
            @(posedge clk);
            rst_b <= 1'b0;
            cyc(3);
            check("outs", {tout, lout}, 0);
            @(posedge clk);
            rst_b <= 1'b1;
            rreg(8'h00, 0);
            $display("second reset test done");
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        rst_b = 0;
        clk_en = 1;
        wr = 0;
        rd = 0;
        addr = 0;
        wdata = 0;
        exp_sig = 0;
        rdo_sig = 0;
        ext_pin = 0;
        fail_count = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_line;
        t_edge(1, 0);
        t_edge(1, 1);
        t_edge(2, 0);
        t_edge(2, 1);
        t_edge(3, 0);
        t_edge(3, 1);
        t_level(0);
        t_level(1);
        t_restart;
        t_reset2;
        wrap_up;
    end
    // run needs about 600 cycles; over thirty times that means a hang
    initial begin
        #200000;
        fail_count = fail_count + 1;
        wrap_up;
    end
endmodule
